// [rtl/svirq_pkg.sv]
// Package: register map, field layout and vectors of the interrupt unit
package svirq_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses on the AXI4-Lite bus)
  // ----------------------------------------------------------------------
  localparam logic [7:0] PRIMARY_IDX   = 8'h0b;
  localparam logic [7:0] SECONDARY_IDX = 8'h1e;
  localparam logic [9:0] PRIMARY_ADDR  = {PRIMARY_IDX, 2'b00};
  localparam logic [9:0] SECONDARY_ADDR = {SECONDARY_IDX, 2'b00};
  // Status of the unit (read only): stack depth and last vector
  localparam logic [9:0] STATUS_ADDR   = 10'h100;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int MASTER_EN_BIT = 0;
  localparam int EXT0_EN_BIT   = 1;
  localparam int EXT1_EN_BIT   = 2;
  localparam int TIMER_EN_BIT  = 3;
  localparam int EXT0_FLAG_BIT = 4;
  localparam int EXT1_FLAG_BIT = 5;
  localparam int TIMER_FLAG_BIT = 6;
  localparam int TB_EN_BIT     = 0;
  localparam int CONV_EN_BIT   = 1;
  localparam int RTC_EN_BIT    = 2;
  localparam int TB_FLAG_BIT   = 4;
  localparam int CONV_FLAG_BIT = 5;
  localparam int RTC_FLAG_BIT  = 6;

  // ----------------------------------------------------------------------
  // Reset values, stack depth, vectors
  // ----------------------------------------------------------------------
  localparam logic [7:0]  PRIMARY_RESET   = 8'h00;
  localparam logic [7:0]  SECONDARY_RESET = 8'h00;
  localparam int          STACK_DEPTH     = 8;
  localparam logic [11:0] VEC_EXT0  = 12'h004;
  localparam logic [11:0] VEC_EXT1  = 12'h008;
  localparam logic [11:0] VEC_TIMER = 12'h00c;
  localparam logic [11:0] VEC_TB    = 12'h010;
  localparam logic [11:0] VEC_CONV  = 12'h014;
  localparam logic [11:0] VEC_RTC   = 12'h018;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : svirq_pkg

// [rtl/svirq_unit.sv]
// Six-source vectored interrupt unit with AXI4-Lite control registers
//
// Operation
// - Two 8-bit control registers at 0BH, 1EH
// - Acknowledge clears master enable, flags still latch
// - No acknowledge while return stack full
// - Entry pushes only program counter, then branches
// - Pin edges set ext flags, bits 4/5
// - Ext requests call 004H/008H, clear flag, master
// - Timer overflow flag bit 6, vector 00CH
// - Time base flag bit 4, vector 010H
// - Conversion done flag bit 5, vector 014H
// - RTC flag bit 6, vector 018H
// - Interrupt return sets master enable; plain return not
// - Requests serviced at next phase-two pulse
// - Fixed priority, ext0 highest, RTC lowest
// - Flags stay set until serviced or cleared
// - Primary bits: master, ext0, ext1, timer; bit7 zero
// - Secondary bits: tb, conv, rtc enables; bits 3,7 zero
// - Any source wakes the halted device
// - Nested accept once master and source re-enabled
// - Return stack holds eight addresses
`timescale 1ns/1ps
`default_nettype none

module svirq_unit #(
  parameter int STACK_DEPTH = svirq_pkg::STACK_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // AXI4-Lite write address, data and response
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Interrupt sources
  input  wire logic        ext_irq_pin_zero_i,
  input  wire logic        ext_irq_pin_one_i,
  input  wire logic [1:0]  ext0_edge_sel_i,
  input  wire logic [1:0]  ext1_edge_sel_i,
  input  wire logic        timer_overflow_i,
  input  wire logic        timebase_timeout_i,
  input  wire logic        conv_done_i,
  input  wire logic        rtc_timeout_i,
  // CPU sequencer
  input  wire logic        machine_phase_two_i,
  input  wire logic        call_push_i,
  input  wire logic        return_i,
  input  wire logic        return_from_irq_instr_i,
  input  wire logic        halted_i,
  // Interrupt entry towards the CPU
  output logic             irq_call_o,
  output logic [11:0]      irq_vector_o,
  output logic             wake_o,
  output logic [3:0]       stack_pointer_o,
  output logic             stack_full_o
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Edge detect; sel[0] falling, sel[1] rising
  function automatic logic edge_hit(input logic cur, input logic prev,
                                    input logic [1:0] sel);
    edge_hit = (sel[0] & prev & ~cur) | (sel[1] & ~prev & cur);
  endfunction : edge_hit

  // Byte-lane 0 write merge for a control register
  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0] s);
    lane0 = s[0] ? d[7:0] : old;
  endfunction : lane0

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [6:0]  prim_reg;
  logic [6:0]  sec_reg;
  logic        pin0_reg;
  logic        pin1_reg;
  logic [3:0]  sp_reg;
  logic        aw_hold_reg;
  logic        w_hold_reg;
  logic [31:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;

  logic [5:0]  req;
  logic [5:0]  grant;
  logic        stk_full;
  logic        ack;
  logic        wr_fire;
  logic        wr_prim;
  logic        wr_sec;
  logic [7:0]  wr_prim_val;
  logic [7:0]  wr_sec_val;
  logic [5:0]  set_ev;

  // ----------------------------------------------------------------------
  // Request resolution
  // ----------------------------------------------------------------------
  // eight-level stack
  assign stk_full = (sp_reg == 4'(STACK_DEPTH));

  always_comb begin
    req[0] = prim_reg[svirq_pkg::EXT0_FLAG_BIT] &
             prim_reg[svirq_pkg::EXT0_EN_BIT];
    req[1] = prim_reg[svirq_pkg::EXT1_FLAG_BIT] &
             prim_reg[svirq_pkg::EXT1_EN_BIT];
    req[2] = prim_reg[svirq_pkg::TIMER_FLAG_BIT] &
             prim_reg[svirq_pkg::TIMER_EN_BIT];
    req[3] = sec_reg[svirq_pkg::TB_FLAG_BIT] & sec_reg[svirq_pkg::TB_EN_BIT];
    req[4] = sec_reg[svirq_pkg::CONV_FLAG_BIT] &
             sec_reg[svirq_pkg::CONV_EN_BIT];
    req[5] = sec_reg[svirq_pkg::RTC_FLAG_BIT] & sec_reg[svirq_pkg::RTC_EN_BIT];
  end

  assign grant = req & (~req + 6'h01);

  // taken on phase two only, master set, stack room
  assign ack = machine_phase_two_i & prim_reg[svirq_pkg::MASTER_EN_BIT] &
               ~stk_full & (|req);

  assign set_ev = {rtc_timeout_i, conv_done_i, timebase_timeout_i,
                   timer_overflow_i,
                   edge_hit(ext_irq_pin_one_i, pin1_reg, ext1_edge_sel_i),
                   edge_hit(ext_irq_pin_zero_i, pin0_reg, ext0_edge_sel_i)};

  // ----------------------------------------------------------------------
  // Bus write decode
  // ----------------------------------------------------------------------
  logic aw_now;
  logic w_now;
  logic [31:0] aw_addr_eff;
  logic [31:0] w_data_eff;
  logic [3:0]  w_strb_eff;

  // A live item counts only once its own ready has taken it
  assign aw_now = aw_hold_reg | (s_axi_awvalid_i & s_axi_awready_o);
  assign w_now  = w_hold_reg | (s_axi_wvalid_i & s_axi_wready_o);
  assign aw_addr_eff = aw_hold_reg ? aw_addr_reg : s_axi_awaddr_i;
  assign w_data_eff  = w_hold_reg ? w_data_reg : s_axi_wdata_i;
  assign w_strb_eff  = w_hold_reg ? w_strb_reg : s_axi_wstrb_i;
  assign wr_fire = aw_now & w_now & ~s_axi_bvalid_o;
  assign wr_prim = wr_fire & (aw_addr_eff[9:0] == svirq_pkg::PRIMARY_ADDR);
  assign wr_sec  = wr_fire & (aw_addr_eff[9:0] == svirq_pkg::SECONDARY_ADDR);
  assign wr_prim_val = lane0({1'b0, prim_reg}, w_data_eff, w_strb_eff);
  assign wr_sec_val  = lane0({1'b0, sec_reg}, w_data_eff, w_strb_eff);

  // Hold address or data that arrives before its partner
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= 32'h0000_0000;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
    end
  end

  // Ready is a registered level: high while nothing is held or answered
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
    end else begin
      s_axi_awready_o <= ~(aw_now & ~wr_fire) & ~wr_fire &
                         ~(s_axi_bvalid_o & ~s_axi_bready_i);
      s_axi_wready_o  <= ~(w_now & ~wr_fire) & ~wr_fire &
                         ~(s_axi_bvalid_o & ~s_axi_bready_i);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= svirq_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= (wr_prim | wr_sec) ? svirq_pkg::RESP_OKAY
                                           : svirq_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin0_reg <= 1'b0;
      pin1_reg <= 1'b0;
    end else begin
      pin0_reg <= ext_irq_pin_zero_i;
      pin1_reg <= ext_irq_pin_one_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prim_reg <= svirq_pkg::PRIMARY_RESET[6:0];
    end else begin
      logic [6:0] nxt;
      nxt = wr_prim ? wr_prim_val[6:0] : prim_reg;
      if (ack) begin
        nxt[svirq_pkg::MASTER_EN_BIT] = 1'b0;
      end
      if (return_from_irq_instr_i) begin
        nxt[svirq_pkg::MASTER_EN_BIT] = 1'b1;
      end
      if (ack && grant[0]) begin
        nxt[svirq_pkg::EXT0_FLAG_BIT] = 1'b0;
      end
      if (ack && grant[1]) begin
        nxt[svirq_pkg::EXT1_FLAG_BIT] = 1'b0;
      end
      if (ack && grant[2]) begin
        nxt[svirq_pkg::TIMER_FLAG_BIT] = 1'b0;
      end
      if (set_ev[0]) begin
        nxt[svirq_pkg::EXT0_FLAG_BIT] = 1'b1;
      end
      if (set_ev[1]) begin
        nxt[svirq_pkg::EXT1_FLAG_BIT] = 1'b1;
      end
      if (set_ev[2]) begin
        nxt[svirq_pkg::TIMER_FLAG_BIT] = 1'b1;
      end
      prim_reg <= nxt;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sec_reg <= svirq_pkg::SECONDARY_RESET[6:0];
    end else begin
      logic [6:0] nxt;
      nxt = wr_sec ? wr_sec_val[6:0] : sec_reg;
      nxt[3] = 1'b0;
      if (ack && grant[3]) begin
        nxt[svirq_pkg::TB_FLAG_BIT] = 1'b0;
      end
      if (ack && grant[4]) begin
        nxt[svirq_pkg::CONV_FLAG_BIT] = 1'b0;
      end
      if (ack && grant[5]) begin
        nxt[svirq_pkg::RTC_FLAG_BIT] = 1'b0;
      end
      if (set_ev[3]) begin
        nxt[svirq_pkg::TB_FLAG_BIT] = 1'b1;
      end
      if (set_ev[4]) begin
        nxt[svirq_pkg::CONV_FLAG_BIT] = 1'b1;
      end
      if (set_ev[5]) begin
        nxt[svirq_pkg::RTC_FLAG_BIT] = 1'b1;
      end
      sec_reg <= nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Return stack depth tracking
  // ----------------------------------------------------------------------
  // only the PC is pushed; a full-stack call overwrites, depth holds
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sp_reg <= 4'h0;
    end else begin
      logic push;
      logic pop;
      push = ack | call_push_i;
      pop  = (return_i | return_from_irq_instr_i) & (sp_reg != 4'h0);
      if (push && !pop && !stk_full) begin
        sp_reg <= sp_reg + 4'h1;
      end else if (pop && !push) begin
        sp_reg <= sp_reg - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Entry outputs
  // ----------------------------------------------------------------------
  // vector of the granted source
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_call_o   <= 1'b0;
      irq_vector_o <= 12'h000;
    end else begin
      irq_call_o <= ack;
      if (ack) begin
        unique case (1'b1)
          grant[0]: irq_vector_o <= svirq_pkg::VEC_EXT0;
          grant[1]: irq_vector_o <= svirq_pkg::VEC_EXT1;
          grant[2]: irq_vector_o <= svirq_pkg::VEC_TIMER;
          grant[3]: irq_vector_o <= svirq_pkg::VEC_TB;
          grant[4]: irq_vector_o <= svirq_pkg::VEC_CONV;
          default:  irq_vector_o <= svirq_pkg::VEC_RTC;
        endcase
      end
    end
  end

  // a newly set flag wakes a halted core
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_o          <= 1'b0;
      stack_pointer_o <= 4'h0;
      stack_full_o    <= 1'b0;
    end else begin
      wake_o          <= halted_i & (|set_ev);
      stack_pointer_o <= sp_reg;
      stack_full_o    <= stk_full;
    end
  end

  // ----------------------------------------------------------------------
  // Bus read
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= svirq_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rresp_o   <= svirq_pkg::RESP_OKAY;
      unique case (s_axi_araddr_i[9:0])
        svirq_pkg::PRIMARY_ADDR:   s_axi_rdata_o <= {25'h0, prim_reg};
        svirq_pkg::SECONDARY_ADDR: s_axi_rdata_o <= {25'h0, sec_reg};
        svirq_pkg::STATUS_ADDR:
          s_axi_rdata_o <= {15'h0, stk_full, irq_vector_o, sp_reg};
        default: begin
          s_axi_rdata_o <= 32'h0000_0000;
          s_axi_rresp_o <= svirq_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_o) begin
      if (s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end else begin
      s_axi_arready_o <= 1'b1;
    end
  end

endmodule : svirq_unit

`default_nettype wire

// [sim/svirq_checker.sv]
// Checker: port-level properties of the interrupt unit
`timescale 1ns/1ps
`default_nettype none

module svirq_checker #(
  parameter int STACK_DEPTH = 8
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rstn_i,
  // CPU sequencer
  input wire logic        machine_phase_two_i,
  input wire logic        call_push_i,
  input wire logic        return_i,
  input wire logic        return_from_irq_instr_i,
  input wire logic        halted_i,
  // Entry side
  input wire logic        irq_call_o,
  input wire logic [11:0] irq_vector_o,
  input wire logic        wake_o,
  input wire logic [3:0]  stack_pointer_o,
  input wire logic        stack_full_o
);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  wire logic sp_move = call_push_i | return_i | return_from_irq_instr_i;

  sequence full_pop_s;
    stack_full_o && !$past(sp_move) &&
    (return_i || return_from_irq_instr_i) && !call_push_i;
  endsequence

  sequence entry_s;
    irq_call_o && !$past(sp_move);
  endsequence

  phase_aligned_call_a: assert property (
    irq_call_o |-> $past(machine_phase_two_i))
    else $error("call not tied to a phase two pulse");
  no_call_full_a: assert property (
    irq_call_o |-> !stack_full_o)
    else $error("call taken with the stack full");
  entry_pushes_a: assert property (
    entry_s |=> stack_pointer_o == $past(stack_pointer_o) + 4'h1)
    else $error("entry did not push exactly one address");
  full_depth_a: assert property (
    stack_full_o == (stack_pointer_o == 4'(STACK_DEPTH)))
    else $error("full flag disagrees with depth");
  pop_from_full_a: assert property (
    full_pop_s |=> !irq_call_o ##1 stack_pointer_o == 4'(STACK_DEPTH - 1))
    else $error("return from full stack mishandled");
  vector_legal_a: assert property (
    irq_call_o |-> irq_vector_o inside {12'h004, 12'h008, 12'h00c,
                                        12'h010, 12'h014, 12'h018})
    else $error("entry vector outside the table");
  single_entry_a: assert property (
    irq_call_o |=> !irq_call_o)
    else $error("back to back entries");
  vector_hold_a: assert property (
    !irq_call_o |-> $stable(irq_vector_o))
    else $error("vector moved without an entry");
  depth_idle_a: assert property (
    !$past(irq_call_o) && !$past(sp_move, 2) |-> $stable(stack_pointer_o))
    else $error("depth moved without cause");
  wake_halted_a: assert property (
    wake_o |-> $past(halted_i))
    else $error("wake while not halted");

endmodule : svirq_checker

`default_nettype wire

// [sim/svirq_cpu_model.sv]
// Partner model: CPU phase sequencer and return stack mirror
`timescale 1ns/1ps
`default_nettype none

module svirq_cpu_model (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rstn_i,
  // Stack traffic
  input wire logic        irq_call_i,
  input wire logic        call_push_i,
  input wire logic        return_i,
  input wire logic        rti_i,
  // Sequencer outputs
  output logic            phase_two_o,
  output logic [3:0]      depth_o
);
  // --------------------------------------------------------------
  // Machine cycle of four clocks, phase two on the second
  // --------------------------------------------------------------
  logic [1:0] cyc_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc_reg <= 2'h0;
    end else begin
      cyc_reg <= cyc_reg + 2'h1;
    end
  end

  assign phase_two_o = (cyc_reg == 2'h1);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      depth_o <= 4'h0;
    end else if ((irq_call_i || call_push_i) && depth_o != 4'h8) begin
      depth_o <= depth_o + 4'h1;
    end else if ((return_i || rti_i) && depth_o != 4'h0) begin
      depth_o <= depth_o - 4'h1;
    end
  end

endmodule : svirq_cpu_model

`default_nettype wire

// [sim/testbench.sv]
// Testbench: registers, vectors, priority, stack limit and wake-up
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        clk_i, rstn_i, s_axi_awvalid_i, s_axi_awready_o;
  logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i, stack_pointer_o, depth;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, ext0_edge_sel_i, ext1_edge_sel_i;
  logic        s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
  logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic        ext_irq_pin_zero_i, ext_irq_pin_one_i, timer_overflow_i;
  logic        timebase_timeout_i, conv_done_i, rtc_timeout_i, halted_i;
  logic        machine_phase_two_i, call_push_i, return_i, wake_o, woke;
  logic        return_from_irq_instr_i, irq_call_o, stack_full_o;
  logic [11:0] irq_vector_o;
  int          n_errors, total_checks, cycles;
  localparam logic [9:0] PA = svirq_pkg::PRIMARY_ADDR;
  localparam logic [9:0] SA = svirq_pkg::SECONDARY_ADDR;

  svirq_unit svirq_unit_i (.clk_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .ext_irq_pin_zero_i,
    .ext_irq_pin_one_i, .ext0_edge_sel_i, .ext1_edge_sel_i, .timer_overflow_i,
    .timebase_timeout_i, .conv_done_i, .rtc_timeout_i, .machine_phase_two_i,
    .call_push_i, .return_i, .return_from_irq_instr_i, .halted_i, .irq_call_o,
    .irq_vector_o, .wake_o, .stack_pointer_o, .stack_full_o);

  svirq_cpu_model svirq_cpu_model_i (.clk_i, .rstn_i, .irq_call_i(irq_call_o),
    .call_push_i, .return_i, .rti_i(return_from_irq_instr_i),
    .phase_two_o(machine_phase_two_i), .depth_o(depth));

  // --------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // --------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (wake_o === 1'b1) woke <= 1'b1;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task automatic axi_wr(input logic [9:0] a, input logic [7:0] d,
                        output logic [1:0] r);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk_i);
    s_axi_awaddr_i <= {22'h0, a};
    s_axi_wdata_i <= {24'h0, d};
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    forever begin
      @(posedge clk_i);
      if (aw && s_axi_awready_o) begin
        aw = 1'b0;
        s_axi_awvalid_i <= 1'b0;
      end
      if (w && s_axi_wready_o) begin
        w = 1'b0;
        s_axi_wvalid_i <= 1'b0;
      end
      if (s_axi_bvalid_o) begin
        r = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        break;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [9:0] a, output logic [7:0] d,
                        output logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr_i <= {22'h0, a};
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
    forever begin
      @(posedge clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o) begin
        d = s_axi_rdata_o[7:0];
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  // Sources are pulsed for one cycle; external pins toggle once
  task automatic fire(input int k);
    @(posedge clk_i);
    case (k)
      0: ext_irq_pin_zero_i <= ~ext_irq_pin_zero_i;
      1: ext_irq_pin_one_i <= ~ext_irq_pin_one_i;
      2: timer_overflow_i <= 1'b1;
      3: timebase_timeout_i <= 1'b1;
      4: conv_done_i <= 1'b1;
      default: rtc_timeout_i <= 1'b1;
    endcase
    @(posedge clk_i);
    {timer_overflow_i, timebase_timeout_i, conv_done_i, rtc_timeout_i} <= 4'h0;
    @(posedge clk_i);
  endtask : fire

  // Extra edge at the end lets the stack update land before checks
  task automatic pulse(input int k);
    @(posedge clk_i);
    {call_push_i, return_i, return_from_irq_instr_i} <= 3'h4 >> k;
    @(posedge clk_i);
    {call_push_i, return_i, return_from_irq_instr_i} <= 3'h0;
    @(posedge clk_i);
  endtask : pulse

  task automatic see_call(output logic got, output logic [11:0] v);
    got = 1'b0;
    v = 12'h000;
    repeat (24) begin
      @(posedge clk_i);
      if (irq_call_o === 1'b1) begin
        got = 1'b1;
        v = irq_vector_o;
        break;
      end
    end
  endtask : see_call

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic regs_test();
    logic [7:0] d;
    logic [1:0] r;
    axi_rd(PA, d, r);
    chk(8'h00, d);
    axi_rd(SA, d, r);
    chk(8'h00, d);
    axi_wr(PA, 8'hfe, r);
    axi_rd(PA, d, r);
    chk(8'h7e, d);
    axi_wr(SA, 8'hff, r);
    axi_rd(SA, d, r);
    chk(8'h77, d);
    axi_rd(10'h3fc, d, r);
    chk(svirq_pkg::RESP_SLVERR, r);
    axi_wr(10'h3fc, 8'h01, r);
    chk(svirq_pkg::RESP_SLVERR, r);
    axi_wr(PA, 8'h00, r);
    axi_wr(SA, 8'h00, r);
  endtask : regs_test

  task automatic vec_test();
    logic [7:0]  p, s, d;
    logic [1:0]  r;
    logic        got;
    logic [11:0] v;
    for (int k = 0; k < 6; k++) begin
      p = (k < 3) ? 8'(2 << k) : 8'h00;
      s = (k < 3) ? 8'h00 : 8'(1 << (k - 3));
      axi_wr(PA, p | 8'h01, r);
      axi_wr(SA, s, r);
      fire(k);
      see_call(got, v);
      chk(12'(4 * (k + 1)), v);
      axi_rd(PA, d, r);
      chk(p, d);
      axi_rd(SA, d, r);
      chk(s, d);
      chk(4'h1, stack_pointer_o);
      pulse(2);
    end
  endtask : vec_test

  task automatic prio_test();
    logic [7:0]  d;
    logic [1:0]  r;
    logic        got;
    logic [11:0] v;
    axi_wr(PA, 8'h00, r);
    axi_wr(SA, 8'h77, r);
    axi_wr(PA, 8'h7f, r);
    for (int k = 0; k < 6; k++) begin
      see_call(got, v);
      chk(12'(4 * (k + 1)), v);
      pulse(2);
    end
    axi_rd(PA, d, r);
    chk(8'h0f, d);
    axi_rd(SA, d, r);
    chk(8'h07, d);
  endtask : prio_test

  task automatic stack_test();
    logic [7:0]  d;
    logic [1:0]  r;
    logic        got;
    logic [11:0] v;
    axi_wr(PA, 8'h00, r);
    axi_wr(SA, 8'h00, r);
    repeat (8) pulse(0);
    @(posedge clk_i);
    chk(1'h1, stack_full_o);
    chk(depth, stack_pointer_o);
    axi_wr(PA, 8'h09, r);
    fire(2);
    see_call(got, v);
    chk(1'h0, got);
    axi_rd(PA, d, r);
    chk(8'h49, d);
    pulse(1);
    see_call(got, v);
    chk(svirq_pkg::VEC_TIMER, v);
    axi_rd(svirq_pkg::STATUS_ADDR, d, r);
    chk(8'hc8, d);
    pulse(1);
    axi_rd(PA, d, r);
    chk(8'h08, d);
    pulse(2);
    axi_rd(PA, d, r);
    chk(8'h09, d);
    repeat (6) pulse(1);
    @(posedge clk_i);
    chk(depth, stack_pointer_o);
    chk(4'h0, stack_pointer_o);
  endtask : stack_test

  task automatic wake_test();
    logic [7:0] d;
    logic [1:0] r;
    axi_wr(PA, 8'h00, r);
    axi_wr(SA, 8'h02, r);
    woke <= 1'b0;
    halted_i <= 1'b1;
    fire(4);
    repeat (8) @(posedge clk_i);
    chk(1'h1, woke);
    halted_i <= 1'b0;
    axi_rd(SA, d, r);
    chk(8'h22, d);
  endtask : wake_test

  initial begin
    {rstn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
    {s_axi_arvalid_i, s_axi_rready_i, halted_i, woke} = 4'h0;
    {s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i} = 96'h0;
    {ext_irq_pin_zero_i, ext_irq_pin_one_i, timer_overflow_i} = 3'h0;
    {timebase_timeout_i, conv_done_i, rtc_timeout_i} = 3'h0;
    {call_push_i, return_i, return_from_irq_instr_i} = 3'h0;
    s_axi_wstrb_i = 4'hf;
    ext0_edge_sel_i = 2'h3;
    ext1_edge_sel_i = 2'h3;
    n_errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    regs_test();
    vec_test();
    prio_test();
    stack_test();
    wake_test();
    conclude();
  end

endmodule : testbench

bind svirq_unit svirq_checker #(.STACK_DEPTH(STACK_DEPTH)) svirq_checker_i (
  .clk_i(clk_i), .rstn_i(rstn_i), .machine_phase_two_i(machine_phase_two_i),
  .call_push_i(call_push_i), .return_i(return_i),
  .return_from_irq_instr_i(return_from_irq_instr_i), .halted_i(halted_i),
  .irq_call_o(irq_call_o), .irq_vector_o(irq_vector_o), .wake_o(wake_o),
  .stack_pointer_o(stack_pointer_o), .stack_full_o(stack_full_o));

`default_nettype wire
